// file: design/fses_regs.vh
/*
 * constants for the host-side flash erase / suspend sequencer:
 * command codes, unlock values, field positions and timing counts.
 * assumes a 10 MHz core clock; unlock addresses/data are not fixed
 * by the device description here, so they are plain defaults.
 */
`ifndef FSES_REGS_VH
`define FSES_REGS_VH

// ****************************************************************
// command codes
// ****************************************************************
`define FSES_CMD_PGM_SUSP_LEGACY 8'h80
`define FSES_CMD_PGM_SUSP 8'h51
`define FSES_CMD_PGM_RES_LEGACY 8'h30
`define FSES_CMD_PGM_RES 8'h50
`define FSES_CMD_ERASE_SUSP 8'hb0
`define FSES_CMD_ERASE_SETUP 8'h80
`define FSES_CMD_CHIP_ERASE 8'h10
`define FSES_CMD_SECT_ERASE 8'h30
`define FSES_CMD_ID_ENTRY 8'h90
`define FSES_CMD_ID_EXIT 8'hf0

// ****************************************************************
// unlock cycles (plain defaults)
// ****************************************************************
`define FSES_UNLOCK1_ADDR 22'h000555
`define FSES_UNLOCK1_DATA 8'haa
`define FSES_UNLOCK2_ADDR 22'h0002aa
`define FSES_UNLOCK2_DATA 8'h55

// ****************************************************************
// opcode field of the user command
// ****************************************************************
`define FSES_OP_CHIP_ERASE 3'h0
`define FSES_OP_SECT_ERASE 3'h1
`define FSES_OP_SECT_ADD 3'h2
`define FSES_OP_PGM_SUSP 3'h3
`define FSES_OP_PGM_RES 3'h4
`define FSES_OP_ERASE_SUSP 3'h5
`define FSES_OP_ID_ENTRY 3'h6
`define FSES_OP_ID_EXIT 3'h7

// ****************************************************************
// status bit positions on the data lines
// ****************************************************************
`define FSES_BIT_DATA_POLLING 7
`define FSES_BIT_TOGGLE_STATUS 6
`define FSES_BIT_WINDOW_EXPIRED 3
`define FSES_BIT_ERASE_SECTOR_TOGGLE 2

// ****************************************************************
// timing
// ****************************************************************
`define FSES_CLK_NS 100
`define FSES_SECT_WINDOW_US 50
`define FSES_SECT_WINDOW_CYC ((`FSES_SECT_WINDOW_US * 1000) / `FSES_CLK_NS)
`define FSES_RES_TO_SUSP_US 100
`define FSES_RES_TO_SUSP_CYC ((`FSES_RES_TO_SUSP_US * 1000 + `FSES_CLK_NS - 1) / `FSES_CLK_NS)
`define FSES_WE_LOW_CYC 2
`define FSES_WE_HIGH_CYC 2

`endif

// file: design/fses_bus_cycle.v
/*
 * one asynchronous flash write or read cycle on the pins.
 * latches addr/data at start, so the caller need not hold them until done.
 */
`timescale 1ns/1ps
module fses_bus_cycle
#(
	parameter AW = 22,
	parameter LOW_CYC = 2,
	parameter HIGH_CYC = 2
)
(
	input wire core_clk,
	input wire rst,
	input wire start,
	input wire rd,
	input wire [AW-1:0] addr,
	input wire [7:0] wdata,
	input wire [7:0] dq_sync,
	output reg done,
	output reg [7:0] rdata,
	output reg [AW-1:0] pin_addr,
	output reg [7:0] pin_dq_out,
	output reg pin_dq_oe,
	output reg pin_ce_n,
	output reg pin_we_n,
	output reg pin_oe_n
);
	localparam S_IDLE = 2'd0;
	localparam S_LOW = 2'd1;
	localparam S_HIGH = 2'd2;
	reg [1:0] state;
	reg [7:0] cnt;
	reg is_rd;

	always @(posedge core_clk)
	begin
		done <= 1'b0;
		if (rst)
		begin
			state <= S_IDLE;
			cnt <= 8'h00;
			is_rd <= 1'b0;
			rdata <= 8'h00;
			pin_addr <= {AW{1'b0}};
			pin_dq_out <= 8'h00;
			pin_dq_oe <= 1'b0;
			pin_ce_n <= 1'b1;
			pin_we_n <= 1'b1;
			pin_oe_n <= 1'b1;
		end
		else
		begin
			case (state)
			S_IDLE:
				if (start)
				begin
					is_rd <= rd;
					pin_addr <= addr;
					pin_dq_out <= wdata;
					pin_dq_oe <= ~rd;
					pin_ce_n <= 1'b0;
					pin_we_n <= rd;
					pin_oe_n <= ~rd;
					cnt <= 8'h00;
					state <= S_LOW;
				end
			S_LOW:
				if (cnt == LOW_CYC[7:0] + 8'h02)
				begin
					rdata <= dq_sync;
					pin_we_n <= 1'b1;
					pin_oe_n <= 1'b1;
					cnt <= 8'h00;
					state <= S_HIGH;
				end
				else
					cnt <= cnt + 8'h01;
			S_HIGH:
				if (cnt == HIGH_CYC[7:0])
				begin
					pin_ce_n <= 1'b1;
					pin_dq_oe <= 1'b0;
					done <= 1'b1;
					state <= S_IDLE;
				end
				else
					cnt <= cnt + 8'h01;
			default:
				state <= S_IDLE;
			endcase
		end
	end
endmodule

// file: design/fses_ctrl.v
/*
 * host-side sequencer driving a parallel nor flash: erase sequences,
 * program suspend/resume (erase suspend is always refused), identification entry/exit,
 * and status polling. assumes the flash pins are the only link and
 * that user commands come on a plain request/ack port.
 */
// Summary of operation
// - host uses dedicated program codes unless legacy_codes selects the legacy ones
// - host refuses a suspend until the minimum resume-to-suspend time has passed
// - chip erase is six write cycles ending with erase command
// - sector erase is six cycles, last carries sector address
// - host refuses every extra sector, since polling outlasts the 50 us window
`timescale 1ns/1ps
`include "fses_regs.vh"
module fses_ctrl
#(
	parameter AW = 22,
	parameter WINDOW_CYC = `FSES_SECT_WINDOW_CYC,
	parameter RES_TO_SUSP_CYC = `FSES_RES_TO_SUSP_CYC
)
(
	input wire core_clk,
	input wire rst,
	input wire cmd_valid,
	input wire [2:0] cmd_op,
	input wire [AW-1:0] cmd_addr,
	input wire legacy_codes,
	output reg cmd_ack,
	output reg cmd_refused,
	output reg busy,
	output reg program_suspended,
	output reg erase_active,
	output reg id_mode,
	output reg [7:0] last_status,
	input wire [7:0] flash_dq_in,
	output wire [7:0] flash_dq_out,
	output wire flash_dq_oe,
	output wire [AW-1:0] flash_addr,
	output wire flash_ce_n,
	output wire flash_we_n,
	output wire flash_oe_n,
	output reg flash_reset_n
);
	// ****************************************************************
	// state
	// ****************************************************************
	localparam S_IDLE = 3'd0;
	localparam S_WRITE = 3'd1;
	localparam S_POLL = 3'd2;
	localparam S_DONE = 3'd3;
	localparam S_RESET = 3'd4;
	reg [2:0] state;
	reg [2:0] step;
	reg [2:0] nsteps;
	reg [2:0] op;
	reg [AW-1:0] op_addr;
	reg [7:0] last_code;
	reg [7:0] dq_meta;
	reg [7:0] dq_sync;
	reg [7:0] prev_poll;
	reg have_prev;
	reg cyc_start;
	reg cyc_wait;
	reg cyc_rd;
	reg [AW-1:0] cyc_addr;
	reg [7:0] cyc_data;
	reg [15:0] res_cnt;
	reg program_active;
	wire cyc_done;
	wire [7:0] cyc_rdata;

	// two flops on the data lines before anything reads them
	always @(posedge core_clk)
	begin
		dq_meta <= flash_dq_in;
		dq_sync <= dq_meta;
	end

	fses_bus_cycle #(.AW(AW), .LOW_CYC(`FSES_WE_LOW_CYC),
		.HIGH_CYC(`FSES_WE_HIGH_CYC)) u_cycle
	(
		.core_clk(core_clk),
		.rst(rst),
		.start(cyc_start),
		.rd(cyc_rd),
		.addr(cyc_addr),
		.wdata(cyc_data),
		.dq_sync(dq_sync),
		.done(cyc_done),
		.rdata(cyc_rdata),
		.pin_addr(flash_addr),
		.pin_dq_out(flash_dq_out),
		.pin_dq_oe(flash_dq_oe),
		.pin_ce_n(flash_ce_n),
		.pin_we_n(flash_we_n),
		.pin_oe_n(flash_oe_n)
	);

	// ****************************************************************
	// sequence step table
	// ****************************************************************
	reg [AW-1:0] next_addr;
	reg [7:0] next_data;
	always @*
	begin
		next_addr = {AW{1'b0}};
		next_data = last_code;
		case (op)
		`FSES_OP_CHIP_ERASE, `FSES_OP_SECT_ERASE:
			case (step)
			3'd0, 3'd3:
			begin
				next_addr = `FSES_UNLOCK1_ADDR;
				next_data = `FSES_UNLOCK1_DATA;
			end
			3'd1, 3'd4:
			begin
				next_addr = `FSES_UNLOCK2_ADDR;
				next_data = `FSES_UNLOCK2_DATA;
			end
			3'd2:
			begin
				next_addr = `FSES_UNLOCK1_ADDR;
				next_data = `FSES_CMD_ERASE_SETUP;
			end
			default:
			begin
				next_addr = (op == `FSES_OP_SECT_ERASE) ? op_addr
					: `FSES_UNLOCK1_ADDR;
				next_data = (op == `FSES_OP_SECT_ERASE)
					? `FSES_CMD_SECT_ERASE : `FSES_CMD_CHIP_ERASE;
			end
			endcase
		`FSES_OP_ID_ENTRY:
			case (step)
			3'd0:
			begin
				next_addr = `FSES_UNLOCK1_ADDR;
				next_data = `FSES_UNLOCK1_DATA;
			end
			3'd1:
			begin
				next_addr = `FSES_UNLOCK2_ADDR;
				next_data = `FSES_UNLOCK2_DATA;
			end
			default:
			begin
				next_addr = `FSES_UNLOCK1_ADDR;
				next_data = `FSES_CMD_ID_ENTRY;
			end
			endcase
		`FSES_OP_SECT_ADD:
		begin
			next_addr = op_addr;
			next_data = `FSES_CMD_SECT_ERASE;
		end
		default:
			// single cycles keep a don't-care address of zero
			next_addr = {AW{1'b0}};
		endcase
	end

	// ****************************************************************
	// command acceptance and sequencing
	// ****************************************************************
	always @(posedge core_clk)
	begin
		cmd_ack <= 1'b0;
		cmd_refused <= 1'b0;
		cyc_start <= 1'b0;
		if (res_cnt != 16'h0000)
			res_cnt <= res_cnt - 16'h0001;
		if (rst)
		begin
			state <= S_RESET;
			step <= 3'd0;
			nsteps <= 3'd0;
			op <= 3'd0;
			op_addr <= {AW{1'b0}};
			last_code <= 8'h00;
			cyc_rd <= 1'b0;
			cyc_addr <= {AW{1'b0}};
			cyc_data <= 8'h00;
			prev_poll <= 8'h00;
			have_prev <= 1'b0;
			cyc_wait <= 1'b0;
			res_cnt <= 16'h0000;
			busy <= 1'b1;
			program_suspended <= 1'b0;
			program_active <= 1'b0;
			erase_active <= 1'b0;
			id_mode <= 1'b0;
			last_status <= 8'h00;
			// pulse the flash reset; any erase ends there
			flash_reset_n <= 1'b0;
		end
		else
		begin
			case (state)
			S_RESET:
			begin
				flash_reset_n <= 1'b1;
				busy <= 1'b0;
				state <= S_IDLE;
			end
			S_IDLE:
				if (cmd_valid)
				begin
					op <= cmd_op;
					op_addr <= cmd_addr;
					step <= 3'd0;
					have_prev <= 1'b0;
					case (cmd_op)
					`FSES_OP_CHIP_ERASE, `FSES_OP_SECT_ERASE:
						nsteps <= 3'd5;
					`FSES_OP_ID_ENTRY:
						nsteps <= 3'd2;
					default:
						nsteps <= 3'd0;
					endcase
					if (cmd_op == `FSES_OP_PGM_SUSP)
						last_code <= legacy_codes
							? `FSES_CMD_PGM_SUSP_LEGACY : `FSES_CMD_PGM_SUSP;
					else if (cmd_op == `FSES_OP_PGM_RES)
						last_code <= legacy_codes
							? `FSES_CMD_PGM_RES_LEGACY : `FSES_CMD_PGM_RES;
					else if (cmd_op == `FSES_OP_ERASE_SUSP)
						last_code <= `FSES_CMD_ERASE_SUSP;
					else
						last_code <= `FSES_CMD_ID_EXIT;
					// add-sector refused: polling outlasts the window
					if ((cmd_op == `FSES_OP_ID_ENTRY && program_active &&
						!program_suspended) ||
						(cmd_op == `FSES_OP_PGM_SUSP &&
						res_cnt != 16'h0000) ||
						(cmd_op == `FSES_OP_SECT_ADD) ||
						(cmd_op == `FSES_OP_ERASE_SUSP) ||
						(cmd_op == `FSES_OP_PGM_RES && !program_suspended))
					begin
						cmd_ack <= 1'b1;
						cmd_refused <= 1'b1;
					end
					else
					begin
						busy <= 1'b1;
						state <= S_WRITE;
					end
				end
			S_WRITE:
				// one bus cycle at a time, so no start is lost
				if (!cyc_wait)
				begin
					cyc_rd <= 1'b0;
					cyc_addr <= next_addr;
					cyc_data <= next_data;
					cyc_start <= 1'b1;
					cyc_wait <= 1'b1;
				end
				else if (cyc_done)
				begin
					cyc_wait <= 1'b0;
					if (step != nsteps)
						step <= step + 3'd1;
					else if (op == `FSES_OP_CHIP_ERASE ||
						op == `FSES_OP_SECT_ERASE)
					begin
						// window starts at the final strobe
						erase_active <= 1'b1;
						cyc_rd <= 1'b1;
						cyc_start <= 1'b1;
						state <= S_POLL;
					end
					else
						state <= S_DONE;
				end
			S_POLL:
				if (cyc_done)
				begin
					last_status <= cyc_rdata;
					prev_poll <= cyc_rdata;
					have_prev <= 1'b1;
					if (have_prev && (cyc_rdata[`FSES_BIT_TOGGLE_STATUS] ==
						prev_poll[`FSES_BIT_TOGGLE_STATUS]))
						state <= S_DONE;
					else
						cyc_start <= 1'b1;
				end
			S_DONE:
			begin
				cyc_rd <= 1'b0;
				busy <= 1'b0;
				cmd_ack <= 1'b1;
				state <= S_IDLE;
				case (op)
				`FSES_OP_PGM_SUSP:
					program_suspended <= 1'b1;
				`FSES_OP_PGM_RES:
				begin
					program_suspended <= 1'b0;
					res_cnt <= RES_TO_SUSP_CYC[15:0];
				end
				`FSES_OP_ID_ENTRY:
					id_mode <= 1'b1;
				`FSES_OP_ID_EXIT:
					// exit returns to any program suspend held
					id_mode <= 1'b0;
				default:
					erase_active <= 1'b0;
				endcase
			end
			default:
				state <= S_IDLE;
			endcase
		end
	end
endmodule

// file: verification/fses_ctrl_props.sv
/*
 * checker on the sequencer's user and flash pins.
 * assumes one core clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module fses_ctrl_props
#(
	parameter AW = 22
)
(
	input wire core_clk,
	input wire rst,
	input wire cmd_ack,
	input wire cmd_refused,
	input wire busy,
	input wire program_suspended,
	input wire erase_active,
	input wire id_mode,
	input wire [7:0] flash_dq_out,
	input wire flash_dq_oe,
	input wire [AW-1:0] flash_addr,
	input wire flash_ce_n,
	input wire flash_we_n,
	input wire flash_oe_n,
	input wire flash_reset_n
);
	// ********
	// assertions
	// ********
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	AST_REFUSE_ACK: assert property (cmd_refused |-> cmd_ack)
		else $error("refusal without ack");
	AST_ACK_ONCE: assert property (cmd_ack |=> !cmd_ack)
		else $error("ack longer than one cycle");
	AST_REFUSE_KEEPS: assert property (cmd_refused |->
		$stable(program_suspended) && $stable(id_mode))
		else $error("refused command changed state");
	AST_STROBE_HOLD: assert property ($rose(flash_we_n) |->
		!flash_ce_n && flash_dq_oe && $stable(flash_dq_out)
		&& $stable(flash_addr))
		else $error("write cycle unstable at strobe rise");
	AST_WE_WIDTH: assert property ($fell(flash_we_n) |->
		!flash_we_n[*4])
		else $error("write strobe too short");
	AST_CE_RELEASE: assert property ($rose(flash_we_n) |->
		##[1:4] flash_ce_n)
		else $error("chip select held after write");
	AST_READ_BUS: assert property (!flash_oe_n |->
		flash_we_n && !flash_dq_oe)
		else $error("bus driven during read");
	AST_ERASE_BUSY: assert property (erase_active |-> busy)
		else $error("erase active while idle");
	AST_RESET_PIN: assert property (disable iff (1'b0)
		rst |=> !flash_reset_n)
		else $error("flash reset not driven");
	C_REFUSED: cover property (cmd_ack && cmd_refused);
	C_SUSPEND: cover property ($rose(program_suspended));
	C_ERASE: cover property ($fell(erase_active));
endmodule
bind fses_ctrl fses_ctrl_props #(.AW(AW)) u_props (.core_clk, .rst,
	.cmd_ack, .cmd_refused, .busy, .program_suspended, .erase_active,
	.id_mode, .flash_dq_out, .flash_dq_oe, .flash_addr, .flash_ce_n,
	.flash_we_n, .flash_oe_n, .flash_reset_n);

// file: verification/fses_flash_model.sv
/*
 * pin-level flash model: six-cycle erase with toggling status.
 * assumes the sequencer under test drives every pin.
 */
`timescale 1ns/1ps
module fses_flash_model
#(
	parameter AW = 22,
	parameter ERASE_READS = 6
)
(
	input wire [AW-1:0] addr,
	input wire [7:0] din,
	input wire ce_n,
	input wire we_n,
	input wire oe_n,
	input wire reset_n,
	output reg [7:0] dout = 8'h00,
	output reg [7:0] last_code = 8'h00,
	output reg [AW-1:0] sect_addr = {AW{1'b0}},
	output wire erasing
);
	reg [39:0] hist = 40'h0;
	reg tog = 1'b0;
	integer left = 0;
	assign erasing = (left > 0);
	// ********
	// bus cycles
	// ********
	// taken at strobe rise
	always @(posedge we_n)
	begin
		if (!ce_n && reset_n)
		begin
			last_code = din;
			if (!erasing && hist == 40'haa5580aa55 &&
				(din == 8'h10 || din == 8'h30))
			begin
				left = ERASE_READS;
				if (din == 8'h30)
					sect_addr = addr;
			end
			else if (!erasing)
				hist = {hist[31:0], din};
		end
	end
	always @(negedge oe_n)
	begin
		tog = ~tog;
		if (!ce_n)
			dout = erasing ? {1'b0, tog, 3'b001, tog, 2'b00} : 8'hff;
		if (!ce_n && erasing)
			left = left - 1;
	end
	// released bus shows the inverse, never a held value
	always @(posedge oe_n)
		dout = ~dout;
	always @(negedge reset_n)
		left = 0;
endmodule

// file: verification/tb_fses_ctrl.sv
/*
 * self-checking bench: sequencer against the pin-level flash model.
 * assumes the flash model and the checker are compiled before it.
 */
`timescale 1ns/1ps
module tb_fses_ctrl;
	localparam AW = 22;
	reg core_clk = 1'b0;
	reg rst = 1'b1;
	reg cmd_valid = 1'b0;
	reg [2:0] cmd_op = 3'h0;
	reg [AW-1:0] cmd_addr = 22'h000000;
	reg legacy_codes = 1'b0;
	wire cmd_ack, cmd_refused, busy, program_suspended, erase_active;
	wire id_mode, flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
	wire flash_reset_n, erasing;
	wire [7:0] last_status, flash_dq_in, flash_dq_out, dout, code;
	wire [AW-1:0] flash_addr, sect;
	integer err_count = 0;
	integer n_tests = 0;
	integer seed = 32'hf2eb;
	reg [31:0] rnd;
	reg r;
	reg [7:0] exp_code = 8'h00;
	reg [AW-1:0] exp_addr = 22'h000000;
	logic [32:0] got, want;
	logic [32:0] expq[$];
	// op, legacy, {refused, suspended, id}, last code
	logic [14:0] steps [0:13] = '{
		{3'h4, 1'b0, 3'b100, 8'h00}, {3'h3, 1'b0, 3'b010, 8'h51},
		{3'h6, 1'b0, 3'b011, 8'h90}, {3'h7, 1'b0, 3'b010, 8'hf0},
		{3'h4, 1'b0, 3'b000, 8'h50}, {3'h4, 1'b0, 3'b100, 8'h00},
		{3'h3, 1'b0, 3'b100, 8'h00}, {3'h3, 1'b1, 3'b010, 8'h80},
		{3'h4, 1'b1, 3'b000, 8'h30}, {3'h2, 1'b0, 3'b100, 8'h00},
		{3'h5, 1'b0, 3'b100, 8'h00}, {3'h0, 1'b0, 3'b000, 8'h10},
		{3'h1, 1'b0, 3'b000, 8'h30}, {3'h1, 1'b0, 3'b000, 8'h30}};
	assign flash_dq_in = flash_dq_oe ? flash_dq_out : dout;
	fses_ctrl #(.AW(AW), .WINDOW_CYC(20), .RES_TO_SUSP_CYC(40)) uut (
		.core_clk, .rst, .cmd_valid, .cmd_op, .cmd_addr, .legacy_codes,
		.cmd_ack, .cmd_refused, .busy, .program_suspended, .erase_active,
		.id_mode, .last_status, .flash_dq_in, .flash_dq_out, .flash_dq_oe,
		.flash_addr, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_reset_n);
	fses_flash_model #(.AW(AW), .ERASE_READS(6)) u_flash (
		.addr(flash_addr), .din(flash_dq_out), .ce_n(flash_ce_n),
		.we_n(flash_we_n), .oe_n(flash_oe_n), .reset_n(flash_reset_n),
		.dout, .last_code(code), .sect_addr(sect), .erasing);
	// ********
	// tasks
	// ********
	task check(input string what, input logic [32:0] seen, exp);
		n_tests = n_tests + 1;
		if (seen !== exp)
		begin
			err_count = err_count + 1;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task end_sim;
		$display("checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// request held until ack, then dropped on the next falling edge
	task do_cmd(input [14:0] s, input [AW-1:0] a);
		integer t;
		if (!s[10])
			exp_code = s[7:0];
		if (s[14:12] == 3'h1)
			exp_addr = a;
		expq.push_back({exp_addr, s[10:8], exp_code});
		@(negedge core_clk);
		{cmd_op, legacy_codes, cmd_addr, cmd_valid} = {s[14:11], a, 1'b1};
		t = 0;
		while (cmd_ack !== 1'b1 && t < 20000)
		begin
			@(posedge core_clk);
			#1;
			t = t + 1;
		end
		@(negedge core_clk);
		cmd_valid = 1'b0;
	endtask
	initial
		forever #50 core_clk = ~core_clk;
	// levels are read one cycle after the ack so they have settled
	initial
		forever
		begin
			@(posedge core_clk);
			#1;
			if (cmd_ack === 1'b1)
			begin
				r = cmd_refused;
				@(posedge core_clk);
				#1;
				got = {sect, r, program_suspended, id_mode, code};
				want = expq.size() > 0 ? expq.pop_front() : 33'hx;
				check("command", got, want);
			end
		end
	initial
	begin
		repeat (10) @(negedge core_clk);
		rst = 1'b0;
		repeat (3) @(negedge core_clk);
		foreach (steps[k])
		begin
			if (k == 7)
				repeat (60) @(negedge core_clk);
			rnd = $random(seed);
			do_cmd(steps[k], rnd[AW-1:0]);
		end
		repeat (5) @(negedge core_clk);
		check("pending", expq.size(), 33'h0);
		check("status", last_status, 33'hff);
		check("idle", {busy, erase_active}, 33'h0);
		// reset in mid-erase must stop the flash
		@(negedge core_clk);
		{cmd_op, cmd_valid} = {3'h0, 1'b1};
		wait (erasing === 1'b1);
		repeat (6) @(negedge core_clk);
		check("erasing", {busy, erase_active}, 33'h3);
		{rst, cmd_valid} = 2'b10;
		repeat (2) @(negedge core_clk);
		rst = 1'b0;
		check("erase cut", {erasing, flash_reset_n}, 33'h0);
		repeat (2) @(negedge core_clk);
		check("after reset", {busy, flash_reset_n}, 33'h1);
		end_sim;
	end
	// the run needs under two thousand cycles; this allows ten times that
	initial
	begin
		#2000000;
		err_count = err_count + 1;
		end_sim;
	end
endmodule
